// ==== brc_pkg.sv ====
// Package for the boost regulator control block
package brc_pkg;
  localparam logic [7:0] BRC_BOOST_CONTROL_ADDR = 8'h66;
  localparam int BRC_VOLT_LSB = 0;
  localparam int BRC_NORM_LSB = 2;
  localparam int BRC_STBY_LSB = 5;
  localparam logic [7:0] BRC_WRITE_MASK = 8'h63;
  localparam logic [1:0] BRC_VOLT_RESET = 2'h0;
  localparam logic [1:0] BRC_NORM_RESET = 2'h2;
  localparam logic [1:0] BRC_STBY_RESET = 2'h2;
  localparam int BRC_SLOT_W = 5;
  localparam int BRC_LOAD_W = 8;
  localparam logic [7:0] BRC_LOAD_THRESH = 8'h20;

  typedef enum logic [1:0] {
    BRC_SW_OFF = 2'h0,
    BRC_SW_PFM = 2'h1,
    BRC_SW_AUTO = 2'h2,
    BRC_SW_SKIP = 2'h3
  } brc_mode_t;

  typedef struct packed {
    logic enable;
    logic [1:0] voltage;
    logic pulse_frequency_operation;
    logic pulse_skip_operation;
  } brc_stage_t;
endpackage : brc_pkg

// ==== brc_auto_select.sv ====
// Load based choice between pulse-frequency and pulse-skip operation
`timescale 1ns/1ps
`default_nettype none
module brc_auto_select
  import brc_pkg::*;
#(
  parameter int LOAD_W = BRC_LOAD_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [LOAD_W-1:0] load_level,
  input wire logic [LOAD_W-1:0] load_thresh,
  output logic use_skip
);
  logic use_skip_reg;
  logic use_skip_next;

  always_comb begin
    use_skip_next = (load_level >= load_thresh);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      use_skip_reg <= 1'b0;
    end else begin
      use_skip_reg <= use_skip_next;
    end
  end

  assign use_skip = use_skip_reg;
endmodule : brc_auto_select
`default_nettype wire

// ==== brc_top.sv ====
// Boost regulator control register and mode logic
`timescale 1ns/1ps
`default_nettype none
module brc_top
  import brc_pkg::*;
#(
  parameter int LOAD_W = BRC_LOAD_W,
  parameter logic [7:0] LOAD_THRESH = BRC_LOAD_THRESH
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [BRC_SLOT_W-1:0] boost_powerup_slot,
  input wire logic seq_start,
  input wire logic standby,
  input wire logic [LOAD_W-1:0] load_level,
  output logic in_sequence,
  output brc_stage_t stage
);
  logic [1:0] volt_reg;
  logic [1:0] volt_next;
  logic [1:0] norm_reg;
  logic [1:0] norm_next;
  logic [1:0] stby_reg;
  logic [1:0] stby_next;
  logic on_reg;
  logic on_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  brc_stage_t stage_reg;
  brc_stage_t stage_next;
  logic [1:0] standby_sync;
  logic [1:0] seq_sync;
  logic use_skip;
  logic hit;
  logic [1:0] act_mode;

  // Pins cross in from the power sequencer's pad domain
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      standby_sync <= 2'h0;
      seq_sync <= 2'h0;
    end else begin
      standby_sync <= {standby_sync[0], standby};
      seq_sync <= {seq_sync[0], seq_start};
    end
  end

  brc_auto_select #(.LOAD_W(LOAD_W)) u_auto (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load_level(load_level),
    .load_thresh(LOAD_THRESH[LOAD_W-1:0]),
    .use_skip(use_skip)
  );

  function automatic logic [7:0] pack_reg(input logic [1:0] v,
                                          input logic [1:0] n,
                                          input logic [1:0] s);
    pack_reg = 8'h00;
    pack_reg[BRC_VOLT_LSB +: 2] = v;
    pack_reg[BRC_NORM_LSB +: 2] = n;
    pack_reg[BRC_STBY_LSB +: 2] = s;
  endfunction : pack_reg

  assign hit = reg_wr && (reg_addr == BRC_BOOST_CONTROL_ADDR);
  assign in_sequence = (boost_powerup_slot != '0);

  always_comb begin
    volt_next = volt_reg;
    stby_next = stby_reg;
    norm_next = norm_reg;
    on_next = on_reg;
    if (hit) begin
      // Only writable fields take data; others keep their value
      volt_next = reg_wdata[BRC_VOLT_LSB +: 2];
      stby_next = reg_wdata[BRC_STBY_LSB +: 2];
    end
    if (seq_sync[1] && in_sequence) begin
      on_next = 1'b1;
      norm_next = BRC_SW_AUTO;
    end
    rdata_next = pack_reg(volt_next, norm_next, stby_next);
  end

  // Stage controls come from flip-flops so the power stage never sees
  // a decode glitch while the mode field or the load decision changes
  always_comb begin
    act_mode = standby_sync[1] ? stby_reg : norm_reg;
    stage_next.enable = on_reg && (act_mode != BRC_SW_OFF);
    stage_next.voltage = volt_reg;
    stage_next.pulse_frequency_operation = 1'b0;
    stage_next.pulse_skip_operation = 1'b0;
    case (act_mode)
      BRC_SW_PFM: stage_next.pulse_frequency_operation = on_reg;
      BRC_SW_SKIP: stage_next.pulse_skip_operation = on_reg;
      BRC_SW_AUTO: begin
        stage_next.pulse_skip_operation = on_reg && use_skip;
        stage_next.pulse_frequency_operation = on_reg && !use_skip;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      volt_reg <= BRC_VOLT_RESET;
      norm_reg <= BRC_NORM_RESET;
      stby_reg <= BRC_STBY_RESET;
      on_reg <= 1'b0;
      rdata_reg <= pack_reg(BRC_VOLT_RESET, BRC_NORM_RESET, BRC_STBY_RESET);
      stage_reg <= '0;
    end else begin
      volt_reg <= volt_next;
      norm_reg <= norm_next;
      stby_reg <= stby_next;
      on_reg <= on_next;
      rdata_reg <= rdata_next;
      stage_reg <= stage_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign stage = stage_reg;

  // Fixed and unused bits are judged at reg_rdata, the only place software
  // sees them, so a packing slip is caught as well as a stray write
  AST_NORM_FIXED: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    reg_rdata[BRC_NORM_LSB +: 2] == BRC_SW_AUTO)
    else $error("normal mode changed");
  AST_UNUSED_ZERO: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    reg_rdata[4] == 1'b0 && reg_rdata[7] == 1'b0)
    else $error("unused bit set");
  AST_VOLT_WRITE: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    hit |=> reg_rdata[1:0] == $past(reg_wdata[1:0]))
    else $error("voltage write lost");
  AST_STBY_WRITE: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    hit |=> reg_rdata[6:5] == $past(reg_wdata[6:5]))
    else $error("standby write lost");
  AST_RO_KEEP: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    hit |=> (reg_rdata & ~BRC_WRITE_MASK) ==
      ($past(reg_rdata) & ~BRC_WRITE_MASK))
    else $error("fixed bits took write data");
  AST_MISS_KEEP: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !hit |=> $stable(reg_rdata))
    else $error("readback moved without write");
  AST_RESET_READ: assert property (
    @(posedge sys_clk)
    sys_rst |=> reg_rdata == {1'b0, BRC_STBY_RESET, 1'b0, BRC_NORM_RESET,
      BRC_VOLT_RESET})
    else $error("readback not at reset value");
  AST_RESET_STAGE: assert property (
    @(posedge sys_clk)
    sys_rst |=> stage == '0 && !on_reg)
    else $error("stage active after reset");
  AST_NO_SEQ: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (boost_powerup_slot == '0 && !on_reg) |=> !on_reg)
    else $error("started without slot");
  AST_SEQ_ON: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (seq_sync[1] && in_sequence) |=> on_reg)
    else $error("sequenced start missed");
  AST_IDLE_OFF: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !on_reg |=> !stage.enable)
    else $error("stage enabled before start");
  AST_START_AUTO: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(on_reg) |-> reg_rdata[BRC_NORM_LSB +: 2] == BRC_SW_AUTO)
    else $error("start not auto");
  AST_AUTO_SKIP: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (on_reg && act_mode == BRC_SW_AUTO && use_skip) |=>
    stage.pulse_skip_operation)
    else $error("auto skip missing");
  AST_AUTO_PFM: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (on_reg && act_mode == BRC_SW_AUTO && !use_skip) |=>
    stage.pulse_frequency_operation)
    else $error("auto pfm missing");
  AST_ONE_MODE: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !(stage.pulse_frequency_operation && stage.pulse_skip_operation))
    else $error("both switching modes on");
  AST_PFM_MODE: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (on_reg && act_mode == BRC_SW_PFM) |=>
    stage.pulse_frequency_operation && !stage.pulse_skip_operation)
    else $error("forced pfm not applied");
  AST_SKIP_MODE: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (on_reg && act_mode == BRC_SW_SKIP) |=>
    stage.pulse_skip_operation && !stage.pulse_frequency_operation)
    else $error("forced skip not applied");
  AST_OFF_MODE: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (act_mode == BRC_SW_OFF) |=> !stage.enable)
    else $error("off mode left stage on");
  AST_VOLT_OUT: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ##1 stage.voltage == $past(volt_reg))
    else $error("voltage not driven");
  COV_START: cover property (@(posedge sys_clk) $rose(on_reg));
  COV_STBY: cover property (@(posedge sys_clk) on_reg && standby_sync[1]);
  COV_WR: cover property (@(posedge sys_clk) hit);
  COV_SKIP: cover property (@(posedge sys_clk) stage.pulse_skip_operation);
  COV_OFF: cover property (@(posedge sys_clk)
    on_reg && act_mode == BRC_SW_OFF);
endmodule : brc_top
`default_nettype wire

// ==== brc_stage_model.sv ====
// Behavioural boost power stage that reports its sensed load current
`timescale 1ns/1ps
`default_nettype none
module brc_stage_model
  import brc_pkg::*;
(
  input wire brc_stage_t stage,
  input wire logic sys_clk,
  input wire logic [BRC_LOAD_W-1:0] demand,
  output logic [BRC_LOAD_W-1:0] load_level
);
  // A stage that is not switching carries no inductor current to sense
  always_ff @(posedge sys_clk) begin
    load_level <= stage.enable ? demand : '0;
  end
endmodule : brc_stage_model
`default_nettype wire

// ==== boost_regulator_control_bench.sv ====
// Self-checking bench for the boost regulator control block
`timescale 1ns/1ps
`default_nettype none
module boost_regulator_control_bench;
  import brc_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [BRC_SLOT_W-1:0] slot = 5'h00;
  logic seq_start = 1'b0;
  logic standby = 1'b0;
  logic [BRC_LOAD_W-1:0] demand = 8'h00;
  logic [BRC_LOAD_W-1:0] load_level;
  logic in_sequence;
  brc_stage_t stage;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  always #2.5 sys_clk = ~sys_clk;

  brc_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .boost_powerup_slot(slot), .seq_start(seq_start), .standby(standby),
    .load_level(load_level), .in_sequence(in_sequence), .stage(stage));
  brc_stage_model u_stage (.stage(stage), .sys_clk(sys_clk),
    .demand(demand), .load_level(load_level));

  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    @(negedge sys_clk);
  endtask : wr

  task automatic start_seq();
    @(negedge sys_clk);
    seq_start = 1'b1;
    @(negedge sys_clk);
    seq_start = 1'b0;
    repeat (6) @(negedge sys_clk);
  endtask : start_seq

  task automatic t_reset();
    chk("rdata", 8'h48, reg_rdata);
    chk("stage", 8'h00, {3'h0, stage});
  endtask : t_reset

  task automatic t_writes();
    wr(BRC_BOOST_CONTROL_ADDR, 8'hff);
    chk("rdata", 8'h6b, reg_rdata);
    wr(8'h65, 8'h00);
    chk("rdata", 8'h6b, reg_rdata);
    wr(BRC_BOOST_CONTROL_ADDR, 8'h00);
    chk("rdata", 8'h08, reg_rdata);
  endtask : t_writes

  task automatic t_seq();
    chk("in_sequence", 8'h00, {7'h0, in_sequence});
    start_seq();
    chk("enable", 8'h00, {7'h0, stage.enable});
    slot = 5'h01;
    // Standby mode set to PULSE_FREQUENCY_OPERATION and top voltage code for later checks
    wr(BRC_BOOST_CONTROL_ADDR, 8'h23);
    chk("in_sequence", 8'h01, {7'h0, in_sequence});
    start_seq();
    chk("enable", 8'h01, {7'h0, stage.enable});
    chk("rdata", 8'h2b, reg_rdata);
  endtask : t_seq

  task automatic t_auto();
    demand = 8'h10;
    repeat (4) @(negedge sys_clk);
    chk("pfm_skip", 8'h02, {6'h0, stage.pulse_frequency_operation,
      stage.pulse_skip_operation});
    demand = BRC_LOAD_THRESH;
    repeat (4) @(negedge sys_clk);
    chk("pfm_skip", 8'h01, {6'h0, stage.pulse_frequency_operation,
      stage.pulse_skip_operation});
    chk("voltage", 8'h03, {6'h0, stage.voltage});
    standby = 1'b1;
    repeat (5) @(negedge sys_clk);
    chk("pfm_skip", 8'h02, {6'h0, stage.pulse_frequency_operation,
      stage.pulse_skip_operation});
    // Light load so that forced skip differs from what auto would pick
    demand = 8'h10;
    wr(BRC_BOOST_CONTROL_ADDR, 8'h63);
    chk("pfm_skip", 8'h01, {6'h0, stage.pulse_frequency_operation,
      stage.pulse_skip_operation});
    chk("rdata", 8'h6b, reg_rdata);
    wr(BRC_BOOST_CONTROL_ADDR, 8'h03);
    chk("enable", 8'h00, {7'h0, stage.enable});
    chk("rdata", 8'h0b, reg_rdata);
  endtask : t_auto

  // Whole run needs about 50 cycles; the ceiling of 2000 leaves wide margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_writes();
    t_seq();
    t_auto();
    complete_run();
  end
endmodule : boost_regulator_control_bench
`default_nettype wire
